// [verilog/ucs_defs.vh]
`ifndef UCS_DEFS_VH
`define UCS_DEFS_VH
// Byte addresses on the register bus
`define UCS_ADDR_STATUS   4'h1
`define UCS_ADDR_COMMAND  4'h2
`define UCS_ADDR_RXDATA   4'h3
`define UCS_ADDR_TXDATA   4'h4
`define UCS_ADDR_MODE     4'h5
`define UCS_ADDR_INTSTAT  4'h6
// Mode register bit positions
`define UCS_MODE_BLOCK    0
`define UCS_MODE_WAKEUP   1
`define UCS_MODE_MDROP    2
`define UCS_MODE_PARITY   3
// Command codes, upper nibble
`define UCS_CMD_NONE      4'h0
`define UCS_CMD_MRP1      4'h1
`define UCS_CMD_RXRST     4'h2
`define UCS_CMD_TXRST     4'h3
`define UCS_CMD_ERRRST    4'h4
`define UCS_CMD_BRKCLR    4'h5
`define UCS_CMD_BRKON     4'h6
`define UCS_CMD_BRKOFF    4'h7
`define UCS_CMD_RTSON     4'h8
`define UCS_CMD_RTSOFF    4'h9
`define UCS_CMD_TMOON     4'ha
`define UCS_CMD_MRP0      4'hb
`define UCS_CMD_TMOOFF    4'hc
`define UCS_CMD_PDON      4'he
`define UCS_CMD_PDOFF     4'hf
// Command register low bits
`define UCS_CR_RXEN       0
`define UCS_CR_RXDIS      1
`define UCS_CR_TXEN       2
`define UCS_CR_TXDIS      3
// Timing: bit time in clocks (16 samples of 4 clocks)
`define UCS_OSR           5'd16
`define UCS_DIV           3'd4
`define UCS_FIFO_DEPTH    5'd16
`define UCS_CMD_GAP       2'd3
`endif

// [verilog/ucs_rx.v]
`timescale 1ns/1ps
`default_nettype none
`include "ucs_defs.vh"
// ****************************************
// Receive shifter with break detection
// ****************************************
module ucs_rx (
    input  wire       clk_i,
    input  wire       rst_i,
    input  wire       ce_i,
    input  wire       tick_i,
    input  wire       run_i,
    input  wire       hunt_i,
    input  wire       par_en_i,
    input  wire       rxd_i,
    output reg        done_o,
    output reg  [7:0] data_o,
    output reg  [2:0] err_o,
    output reg        brk_edge_o
);
    localparam S_IDLE = 3'b001;
    localparam S_DATA = 3'b010;
    localparam S_BRKW = 3'b100;
    reg [2:0] st_ff;
    reg [3:0] ph_ff;
    reg [3:0] bit_ff;
    reg [8:0] sh_ff;
    reg       allz_ff;
    reg [2:0] mark_ff;
    wire [3:0] nbits = par_en_i ? 4'd9 : 4'd8;
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            st_ff <= S_IDLE;
            ph_ff <= 4'h0;
            bit_ff <= 4'h0;
            sh_ff <= 9'h000;
            allz_ff <= 1'b0;
            mark_ff <= 3'h0;
            done_o <= 1'b0;
            data_o <= 8'h00;
            err_o <= 3'h0;
            brk_edge_o <= 1'b0;
        end
        else if (ce_i)
        begin
            done_o <= 1'b0;
            brk_edge_o <= 1'b0;
            if (!run_i || hunt_i)
            begin
                st_ff <= S_IDLE;
                ph_ff <= 4'h0;
            end
            else if (tick_i)
            begin
                case (st_ff)
                    S_IDLE:
                    begin
                        if (!rxd_i)
                        begin
                            ph_ff <= ph_ff + 4'h1;
                            if (ph_ff == 4'h7)
                            begin
                                st_ff <= S_DATA;
                                ph_ff <= 4'h0;
                                bit_ff <= 4'h0;
                                allz_ff <= 1'b1;
                            end
                        end
                        else
                            ph_ff <= 4'h0;
                    end
                    S_DATA:
                    begin
                        ph_ff <= ph_ff + 4'h1;
                        if (ph_ff == 4'hf)
                        begin
                            bit_ff <= bit_ff + 4'h1;
                            if (bit_ff == nbits)
                            begin
                                done_o <= 1'b1;
                                data_o <= sh_ff[7:0];
                                err_o <= {allz_ff & ~rxd_i, ~rxd_i,
                                          par_en_i & (^sh_ff[8:0] ^ 1'b1)};
                                st_ff <= (allz_ff & ~rxd_i) ? S_BRKW : S_IDLE;
                                brk_edge_o <= allz_ff & ~rxd_i;
                                mark_ff <= 3'h0;
                            end
                            else
                            begin
                                sh_ff <= par_en_i ? {rxd_i, sh_ff[8:1]} : {1'b0, rxd_i, sh_ff[7:1]};
                                allz_ff <= allz_ff & ~rxd_i;
                            end
                        end
                    end
                    S_BRKW:
                    begin
                        mark_ff <= rxd_i ? mark_ff + 3'h1 : 3'h0;
                        if (rxd_i && mark_ff == 3'h7)
                        begin
                            brk_edge_o <= 1'b1;
                            st_ff <= S_IDLE;
                        end
                    end
                    default: st_ff <= S_IDLE;
                endcase
            end
        end
    end
endmodule // ucs_rx
`default_nettype wire

// [verilog/ucs_top.v]
// Added by the designer: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "ucs_defs.vh"
// What this block does
// - Several non-conflicting commands per write
// - Commands reset mode pointer
// - Receiver or transmitter reset commands
// - Error reset clears status high bits
// - Clear break change flag
// - Start break only when enabled
// - Break waits for queued characters
// - Stop break, mark one bit
// - Request to send assert, negate
// - Timeout mode stops counter, clears ready
// - Leave timeout mode, flag kept
// - Power down keeps registers
// - Transmitter disable drains queue
// - Transmitter enable raises flags
// - Receiver disable drops partial char unless multidrop mode
// - Receiver enable hunts start bit unless wakeup mode
// - Error flags travel with character
// - Break fills one slot
// - Break edges set change flag
// - Framing error on bad stop
// - Overrun loses waiting character
module ucs_top (
    input  wire       clk_i,
    input  wire       rst_i,
    input  wire       ce_i,
    input  wire [3:0] wb_adr_i,
    input  wire [7:0] wb_dat_i,
    output reg  [7:0] wb_dat_o,
    input  wire       wb_we_i,
    input  wire       wb_sel_i,
    input  wire       wb_cyc_i,
    input  wire       wb_stb_i,
    output reg        wb_ack_o,
    input  wire       rxd_i,
    output reg        txd_o,
    output wire       request_to_send_out_n_o,
    output wire       counter_run_o,
    output wire       mode_ptr_o,
    output wire       power_down_o
);
    // ****************************************
    // Bus slave
    // ****************************************
    wire acc = wb_cyc_i & wb_stb_i & ~wb_ack_o & ce_i;
    wire wr = acc & wb_we_i & wb_sel_i;
    wire rd = acc & ~wb_we_i;
    wire cmd_wr = wr & (wb_adr_i == `UCS_ADDR_COMMAND);
    wire [3:0] cmd = cmd_wr ? wb_dat_i[7:4] : `UCS_CMD_NONE;
    reg [7:0] rdat;
    reg [3:0] mode_ff;
    reg [1:0] gap_ff;
    reg       pd_ff;
    reg       mptr_ff;
    reg       rts_ff;
    reg       tmo_ff;
    reg       ctr_run_ff;
    reg       ctr_rdy_ff;
    reg       brk_chg_ff;
    function hit;
        input [3:0] c;
        input [3:0] code;
        hit = (c == code);
    endfunction
    // Upper commands are honoured only once the gap has passed; early ones are dropped
    wire cmd_ok = (gap_ff == 2'd0) & (~pd_ff | hit(cmd, `UCS_CMD_PDOFF));
    wire [3:0] ecmd = cmd_ok ? cmd : `UCS_CMD_NONE;
    // Low bits act beside upper command
    wire lo_ok = cmd_wr & ~pd_ff;

    // ****************************************
    // Synchroniser and bit clock
    // ****************************************
    reg [2:0] rx_sync_ff;
    reg       rx_ff;
    reg [2:0] div_ff;
    wire tick = (div_ff == `UCS_DIV - 3'd1) & ~pd_ff;
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rx_sync_ff <= 3'b111;
            rx_ff <= 1'b1;
            div_ff <= 3'd0;
        end
        else if (ce_i)
        begin
            rx_sync_ff <= {rx_sync_ff[1:0], rxd_i};
            if (rx_sync_ff[2] == rx_sync_ff[1])
                rx_ff <= rx_sync_ff[2];
            if (!pd_ff)
                div_ff <= tick ? 3'd0 : div_ff + 3'd1;
        end
    end

    // ****************************************
    // Receiver and receive queue
    // ****************************************
    reg        rx_en_ff;
    reg        rx_hunt_ff;
    wire       rx_done;
    wire [7:0] rx_data;
    wire [2:0] rx_err;
    wire       rx_brk_edge;
    wire rx_rst = hit(ecmd, `UCS_CMD_RXRST);
    wire rx_run = (rx_en_ff | mode_ff[`UCS_MODE_MDROP]) & ~pd_ff & ~rx_rst;
    ucs_rx u_rx (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .ce_i       (ce_i),
        .tick_i     (tick),
        .run_i      (rx_run),
        .hunt_i     (rx_hunt_ff),
        .par_en_i   (mode_ff[`UCS_MODE_PARITY]),
        .rxd_i      (rx_ff),
        .done_o     (rx_done),
        .data_o     (rx_data),
        .err_o      (rx_err),
        .brk_edge_o (rx_brk_edge)
    );
    reg [10:0] rxq [0:15];
    reg [3:0]  rq_rd_ff;
    reg [3:0]  rq_wr_ff;
    reg [4:0]  rq_cnt_ff;
    reg [10:0] hold_ff;
    reg        hold_v_ff;
    reg        ovr_ff;
    reg [2:0]  blk_err_ff;
    wire rq_full = (rq_cnt_ff == `UCS_FIFO_DEPTH);
    wire rq_empty = (rq_cnt_ff == 5'd0);
    wire rx_pop = rd & (wb_adr_i == `UCS_ADDR_RXDATA) & ~rq_empty;
    wire rq_push = (hold_v_ff | rx_done) & (~rq_full | rx_pop);
    wire [10:0] push_word = hold_v_ff ? hold_ff : {rx_err, rx_data};
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rx_en_ff <= 1'b0;
            rx_hunt_ff <= 1'b0;
            rq_rd_ff <= 4'h0;
            rq_wr_ff <= 4'h0;
            rq_cnt_ff <= 5'd0;
            hold_ff <= 11'h000;
            hold_v_ff <= 1'b0;
            ovr_ff <= 1'b0;
            blk_err_ff <= 3'h0;
        end
        else if (ce_i)
        begin
            // Enable forces start hunt unless wakeup mode
            rx_hunt_ff <= lo_ok & wb_dat_i[`UCS_CR_RXEN] & ~mode_ff[`UCS_MODE_WAKEUP];
            if (lo_ok & wb_dat_i[`UCS_CR_RXDIS])
                rx_en_ff <= 1'b0;
            else if (lo_ok & wb_dat_i[`UCS_CR_RXEN])
                rx_en_ff <= 1'b1;
            if (rx_rst)
            begin
                rx_en_ff <= 1'b0;
                rq_rd_ff <= 4'h0;
                rq_wr_ff <= 4'h0;
                rq_cnt_ff <= 5'd0;
                hold_v_ff <= 1'b0;
                ovr_ff <= 1'b0;
                blk_err_ff <= 3'h0;
            end
            else
            begin
                if (rq_push)
                begin
                    rxq[rq_wr_ff] <= push_word;
                    rq_wr_ff <= rq_wr_ff + 4'h1;
                    blk_err_ff <= blk_err_ff | push_word[10:8];
                end
                if (rx_pop)
                    rq_rd_ff <= rq_rd_ff + 4'h1;
                rq_cnt_ff <= rq_cnt_ff + {4'h0, rq_push} - {4'h0, rx_pop};
                if (hold_v_ff & rx_done & rq_full & ~rx_pop)
                begin
                    hold_ff <= {rx_err, rx_data};
                    ovr_ff <= 1'b1;
                end
                else if (hold_v_ff & rq_push)
                begin
                    hold_v_ff <= rx_done;
                    hold_ff <= {rx_err, rx_data};
                end
                else if (rx_done & ~rq_push)
                begin
                    hold_v_ff <= 1'b1;
                    hold_ff <= {rx_err, rx_data};
                end
                // Error reset clears errors
                // A character landing in the clear cycle keeps its flags
                if (hit(ecmd, `UCS_CMD_ERRRST))
                begin
                    ovr_ff <= hold_v_ff & rx_done & rq_full & ~rx_pop;
                    blk_err_ff <= rq_push ? push_word[10:8] : 3'h0;
                end
            end
        end
    end
    wire [10:0] rq_top = rxq[rq_rd_ff];
    wire [2:0] err_view = mode_ff[`UCS_MODE_BLOCK] ? blk_err_ff : (rq_empty ? 3'h0 : rq_top[10:8]);
    reg [2:0] err_mask_ff;

    // ****************************************
    // Transmitter
    // ****************************************
    localparam T_IDLE = 4'b0001;
    localparam T_SEND = 4'b0010;
    localparam T_BRK  = 4'b0100;
    localparam T_MARK = 4'b1000;
    reg [3:0] tst_ff;
    reg [7:0] txq [0:15];
    reg [3:0] tq_rd_ff;
    reg [3:0] tq_wr_ff;
    reg [4:0] tq_cnt_ff;
    reg       tx_en_ff;
    reg       tx_emt_ff;
    reg       brk_req_ff;
    reg [9:0] tsh_ff;
    reg [3:0] tph_ff;
    reg [3:0] tbit_ff;
    wire tx_rst = hit(ecmd, `UCS_CMD_TXRST);
    wire tx_push = wr & (wb_adr_i == `UCS_ADDR_TXDATA) & tx_en_ff & (tq_cnt_ff != `UCS_FIFO_DEPTH);
    // Loads go on under a pending break, so the queue drains before it starts
    wire tx_load = (tst_ff == T_IDLE) & tick & (tq_cnt_ff != 5'd0);
    wire tx_space = tx_en_ff & (tq_cnt_ff != `UCS_FIFO_DEPTH);
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            tst_ff <= T_IDLE;
            tq_rd_ff <= 4'h0;
            tq_wr_ff <= 4'h0;
            tq_cnt_ff <= 5'd0;
            tx_en_ff <= 1'b0;
            tx_emt_ff <= 1'b0;
            brk_req_ff <= 1'b0;
            tsh_ff <= 10'h3ff;
            tph_ff <= 4'h0;
            tbit_ff <= 4'h0;
            txd_o <= 1'b1;
        end
        else if (ce_i)
        begin
            if (tx_rst)
            begin
                tst_ff <= T_IDLE;
                tq_rd_ff <= 4'h0;
                tq_wr_ff <= 4'h0;
                tq_cnt_ff <= 5'd0;
                tx_en_ff <= 1'b0;
                tx_emt_ff <= 1'b0;
                brk_req_ff <= 1'b0;
                txd_o <= 1'b1;
            end
            else
            begin
                if (tx_push)
                begin
                    txq[tq_wr_ff] <= wb_dat_i;
                    tq_wr_ff <= tq_wr_ff + 4'h1;
                end
                if (tx_load)
                    tq_rd_ff <= tq_rd_ff + 4'h1;
                tq_cnt_ff <= tq_cnt_ff + {4'h0, tx_push} - {4'h0, tx_load};
                if (lo_ok & wb_dat_i[`UCS_CR_TXDIS])
                    tx_en_ff <= 1'b0;
                else if (lo_ok & wb_dat_i[`UCS_CR_TXEN])
                    tx_en_ff <= 1'b1;
                if (lo_ok & wb_dat_i[`UCS_CR_TXDIS] | tx_push)
                    tx_emt_ff <= 1'b0;
                else if (lo_ok & wb_dat_i[`UCS_CR_TXEN] & (tst_ff == T_IDLE) & (tq_cnt_ff == 5'd0))
                    tx_emt_ff <= 1'b1;
                if (hit(ecmd, `UCS_CMD_BRKON) & tx_en_ff)
                    brk_req_ff <= 1'b1;
                if (tick)
                begin
                    case (tst_ff)
                        T_IDLE:
                        begin
                            txd_o <= 1'b1;
                            if (tx_load)
                            begin
                                tsh_ff <= {1'b1, txq[tq_rd_ff], 1'b0};
                                tst_ff <= T_SEND;
                                tph_ff <= 4'h0;
                                tbit_ff <= 4'h0;
                            end
                            else if (brk_req_ff & (tq_cnt_ff == 5'd0))
                                tst_ff <= T_BRK;
                        end
                        T_SEND:
                        begin
                            txd_o <= tsh_ff[0];
                            tph_ff <= tph_ff + 4'h1;
                            if (tph_ff == 4'hf)
                            begin
                                tsh_ff <= {1'b1, tsh_ff[9:1]};
                                tbit_ff <= tbit_ff + 4'h1;
                                if (tbit_ff == 4'd9)
                                begin
                                    tst_ff <= T_IDLE;
                                    if (tq_cnt_ff == 5'd0 && tx_en_ff)
                                        tx_emt_ff <= 1'b1;
                                end
                            end
                        end
                        T_BRK:
                        begin
                            txd_o <= 1'b0;
                            tph_ff <= 4'h0;
                            if (hit(ecmd, `UCS_CMD_BRKOFF))
                            begin
                                brk_req_ff <= 1'b0;
                                tst_ff <= T_MARK;
                            end
                        end
                        T_MARK:
                        begin
                            txd_o <= 1'b1;
                            tph_ff <= tph_ff + 4'h1;
                            if (tph_ff == 4'hf)
                                tst_ff <= T_IDLE;
                        end
                        default: tst_ff <= T_IDLE;
                    endcase
                end
                else if (tst_ff == T_BRK && hit(ecmd, `UCS_CMD_BRKOFF))
                begin
                    brk_req_ff <= 1'b0;
                    tst_ff <= T_MARK;
                end
            end
        end
    end

    // ****************************************
    // Miscellaneous commands and read back
    // ****************************************
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            mode_ff <= 4'h0;
            gap_ff <= 2'd0;
            pd_ff <= 1'b0;
            mptr_ff <= 1'b1;
            rts_ff <= 1'b0;
            tmo_ff <= 1'b0;
            ctr_run_ff <= 1'b0;
            ctr_rdy_ff <= 1'b0;
            brk_chg_ff <= 1'b0;
            err_mask_ff <= 3'h0;
            wb_ack_o <= 1'b0;
            wb_dat_o <= 8'h00;
        end
        else if (ce_i)
        begin
            wb_ack_o <= acc;
            if (rd)
                wb_dat_o <= rdat;
            // Count the gap between upper commands
            if (ecmd != `UCS_CMD_NONE)
                gap_ff <= `UCS_CMD_GAP - 2'd1;
            else if (gap_ff != 2'd0)
                gap_ff <= gap_ff - 2'd1;
            if (wr & (wb_adr_i == `UCS_ADDR_MODE))
                mode_ff <= wb_dat_i[3:0];
            if (hit(ecmd, `UCS_CMD_MRP1))
                mptr_ff <= 1'b1;
            if (hit(ecmd, `UCS_CMD_MRP0))
                mptr_ff <= 1'b0;
            if (hit(ecmd, `UCS_CMD_RTSON))
                rts_ff <= 1'b1;
            if (hit(ecmd, `UCS_CMD_RTSOFF))
                rts_ff <= 1'b0;
            if (hit(ecmd, `UCS_CMD_TMOON))
            begin
                tmo_ff <= 1'b1;
                ctr_run_ff <= 1'b0;
                ctr_rdy_ff <= 1'b0;
            end
            else if (tmo_ff & rq_push)
                ctr_run_ff <= 1'b1;
            // Timeout mode off keeps counter state
            if (hit(ecmd, `UCS_CMD_TMOOFF))
                tmo_ff <= 1'b0;
            if (hit(ecmd, `UCS_CMD_PDON))
                pd_ff <= 1'b1;
            if (hit(ecmd, `UCS_CMD_PDOFF))
                pd_ff <= 1'b0;
            // Break edge set wins over clear
            if (rx_brk_edge)
                brk_chg_ff <= 1'b1;
            else if (hit(ecmd, `UCS_CMD_BRKCLR))
                brk_chg_ff <= 1'b0;
            // Clear top-of-queue view until next pop
            if (rx_pop | rx_rst)
                err_mask_ff <= 3'h0;
            else if (hit(ecmd, `UCS_CMD_ERRRST))
                err_mask_ff <= 3'h7;
        end
    end
    always @*
    begin
        rdat = 8'h00;
        case (wb_adr_i)
            `UCS_ADDR_STATUS:  rdat = {err_view & ~err_mask_ff, ovr_ff, tx_emt_ff & tx_en_ff, tx_space,
                                       rq_full | hold_v_ff, ~rq_empty};
            `UCS_ADDR_RXDATA:  rdat = rq_empty ? 8'h00 : rq_top[7:0];
            `UCS_ADDR_MODE:    rdat = {4'h0, mode_ff};
            `UCS_ADDR_INTSTAT: rdat = {4'h0, ctr_rdy_ff, brk_chg_ff, 2'b00};
            default:           rdat = 8'h00;
        endcase
    end
    assign request_to_send_out_n_o = ~rts_ff;
    assign counter_run_o = ctr_run_ff;
    assign mode_ptr_o = mptr_ff;
    assign power_down_o = pd_ff;
endmodule // ucs_top
`default_nettype wire

// [bench/ucs_top_sva.sv]
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Bus handshake and command decode checks
// ****************************************
module ucs_top_sva (
    input wire logic       clk_i,
    input wire logic       rst_i,
    input wire logic       ce_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [7:0] wb_dat_i,
    input wire logic       wb_we_i,
    input wire logic       wb_sel_i,
    input wire logic       wb_cyc_i,
    input wire logic       wb_stb_i,
    input wire logic       wb_ack_o,
    input wire logic       request_to_send_out_n_o,
    input wire logic       counter_run_o,
    input wire logic       mode_ptr_o,
    input wire logic       power_down_o
);
    // Wake command must still count while powered down, so gating is kept apart
    wire       wp = wb_cyc_i & wb_stb_i & ce_i & ~wb_ack_o & wb_we_i & wb_sel_i & (wb_adr_i == 4'h2);
    wire       wc = wp & ~power_down_o;
    wire [3:0] c  = wb_dat_i[7:4];
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    a_ack_latency: assert property (wb_cyc_i && wb_stb_i && ce_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
    a_rts_assert: assert property (wc && c == 4'h8 |-> ##[1:2] !request_to_send_out_n_o) else $error("rts on");
    a_rts_negate: assert property (wc && c == 4'h9 |-> ##[1:2] request_to_send_out_n_o) else $error("rts off");
    a_ptr_first: assert property (wc && c == 4'h1 |-> ##[1:2] mode_ptr_o) else $error("ptr first");
    a_ptr_zero: assert property (wc && c == 4'hb |-> ##[1:2] !mode_ptr_o) else $error("ptr zero");
    a_tmo_stop: assert property (wc && c == 4'ha |-> ##[1:2] !counter_run_o) else $error("counter run");
    a_pd_enter: assert property (wc && c == 4'he |-> ##[1:2] power_down_o) else $error("pd enter");
    a_pd_hold: assert property (wp && power_down_o && c == 4'h8 |=> $stable(request_to_send_out_n_o) [*2])
        else $error("cmd in pd");
    a_pd_leave: assert property (wp && power_down_o && c == 4'hf |-> ##[1:2] !power_down_o) else $error("pd leave");
    cover property (wc && c == 4'h8);
    cover property (wp && power_down_o);
    cover property (wc && c == 4'ha);
endmodule // ucs_top_sva
bind ucs_top ucs_top_sva chk (.*);
`default_nettype wire

// [bench/ucs_line.sv]
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Far end serial transmitter
// ****************************************
module ucs_line (
    input wire logic clk_i,
    output var logic rxd_o
);
    initial rxd_o = 1'b1;
    // Lsb first, 64 clocks a bit; stp 0 makes a bad stop bit
    task automatic send(input logic [7:0] d, input logic stp);
        logic [9:0] f;
        f = {stp, d, 1'b0};
        for (int i = 0; i < 10; i++)
        begin
            rxd_o <= f[i];
            repeat (64) @(posedge clk_i);
        end
        rxd_o <= 1'b1;
    endtask
endmodule // ucs_line
`default_nettype wire

// [bench/ucs_top_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module ucs_top_tb;
    logic       clk_i = 1'b0;
    logic       rst_i = 1'b1;
    logic       cyc   = 1'b0;
    logic       we    = 1'b0;
    logic [3:0] adr   = 4'h0;
    logic [7:0] wd    = 8'h00;
    logic [7:0] q;
    wire  [7:0] rdat;
    wire        ack, txd, rts_n, cnt, mptr, pd, rxd;
    int         errors = 0;
    int         num_checks = 0;
    always #20 clk_i = ~clk_i;
    ucs_top dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_adr_i(adr), .wb_dat_i(wd), .wb_dat_o(rdat),
        .wb_we_i(we), .wb_sel_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_ack_o(ack), .rxd_i(rxd), .txd_o(txd),
        .request_to_send_out_n_o(rts_n), .counter_run_o(cnt), .mode_ptr_o(mptr), .power_down_o(pd));
    ucs_line line (.clk_i(clk_i), .rxd_o(rxd));
    // ****************************************
    // Bus and check helpers
    // ****************************************
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
        num_checks++;
        if (s !== e)
        begin
            errors++;
            $display("ERROR %s exp %h got %h", nm, e, s);
        end
    endtask
    task automatic wb(input logic [3:0] a, input logic w, input logic [7:0] d, output logic [7:0] r);
        @(posedge clk_i);
        adr <= a;
        we <= w;
        wd <= d;
        cyc <= 1'b1;
        do @(posedge clk_i); while (ack !== 1'b1);
        r = rdat;
        cyc <= 1'b0;
        repeat (3) @(posedge clk_i);
    endtask
    function automatic logic [7:0] pins();
        return {3'h0, txd, rts_n, mptr, pd, cnt};
    endfunction
    task automatic stop_test();
        if (errors == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset();
        wb(4'h1, 1'b0, 8'h00, q);
        chk("status", 8'h00, q);
        chk("pins", 8'h1c, pins());
        wb(4'h9, 1'b0, 8'h00, q);
        chk("unmapped", 8'h00, q);
    endtask
    task automatic t_tx();
        wb(4'h2, 1'b1, 8'h04, q);
        wb(4'h1, 1'b0, 8'h00, q);
        chk("tx_en", 8'h0c, q & 8'h0c);
        wb(4'h2, 1'b1, 8'h08, q);
        wb(4'h1, 1'b0, 8'h00, q);
        chk("tx_dis", 8'h00, q & 8'h0c);
    endtask
    task automatic t_cmds();
        logic [23:0] cm;
        logic [23:0] ex;
        cm = 24'h8bac91;
        ex = 24'h40008c;
        for (int i = 0; i < 6; i++)
        begin
            wb(4'h2, 1'b1, {cm[23-4*i -: 4], 4'h0}, q);
            chk("cmd_pins", {4'h1, ex[23-4*i -: 4]}, pins());
        end
        wb(4'h2, 1'b1, 8'he0, q);
        chk("pd_on", 8'h1e, pins());
        wb(4'h2, 1'b1, 8'h80, q);
        chk("pd_keep", 8'h1e, pins());
        wb(4'h2, 1'b1, 8'hf0, q);
        chk("pd_off", 8'h1c, pins());
    endtask
    task automatic t_break();
        wb(4'h2, 1'b1, 8'h60, q);
        repeat (130) @(posedge clk_i);
        chk("brk_dis", 8'h01, {7'h0, txd});
        wb(4'h2, 1'b1, 8'h04, q);
        wb(4'h2, 1'b1, 8'h60, q);
        repeat (130) @(posedge clk_i);
        chk("brk_on", 8'h00, {7'h0, txd});
        wb(4'h2, 1'b1, 8'h70, q);
        repeat (130) @(posedge clk_i);
        chk("brk_off", 8'h01, {7'h0, txd});
        wb(4'h4, 1'b1, 8'hff, q);
        wb(4'h4, 1'b1, 8'hff, q);
        wb(4'h2, 1'b1, 8'h60, q);
        chk("tx_start", 8'h00, {7'h0, txd});
        repeat (300) @(posedge clk_i);
        chk("brk_wait", 8'h01, {7'h0, txd});
        repeat (1100) @(posedge clk_i);
        chk("brk_queued", 8'h00, {7'h0, txd});
        wb(4'h2, 1'b1, 8'h70, q);
        wb(4'h2, 1'b1, 8'h08, q);
    endtask
    task automatic t_rx();
        wb(4'h2, 1'b1, 8'h01, q);
        line.send(8'h5a, 1'b0);
        wb(4'h1, 1'b0, 8'h00, q);
        chk("rx_fe", 8'h41, q & 8'hf1);
        wb(4'h3, 1'b0, 8'h00, q);
        chk("rx_data", 8'h5a, q);
        wb(4'h1, 1'b0, 8'h00, q);
        chk("rx_pop", 8'h00, q & 8'hf1);
        line.send(8'h33, 1'b0);
        wb(4'h2, 1'b1, 8'h40, q);
        wb(4'h1, 1'b0, 8'h00, q);
        chk("err_rst", 8'h01, q & 8'hf1);
        wb(4'h2, 1'b1, 8'h20, q);
        wb(4'h1, 1'b0, 8'h00, q);
        chk("rx_rst", 8'h00, q & 8'h03);
        wb(4'h2, 1'b1, 8'h01, q);
        line.send(8'h00, 1'b0);
        repeat (64) @(posedge clk_i);
        wb(4'h1, 1'b0, 8'h00, q);
        chk("rx_brk", 8'hc1, q & 8'hf1);
        wb(4'h6, 1'b0, 8'h00, q);
        chk("brk_chg", 8'h04, q);
        wb(4'h2, 1'b1, 8'h50, q);
        wb(4'h6, 1'b0, 8'h00, q);
        chk("brk_clr", 8'h00, q);
    endtask
    initial
    begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_tx();
        t_cmds();
        t_break();
        t_rx();
        stop_test();
    end
    // Whole run needs about 4000 clocks
    initial
    begin
        repeat (20000) @(posedge clk_i);
        errors++;
        stop_test();
    end
endmodule // ucs_top_tb
`default_nettype wire
